// file: src/sdivr_params.svh
// offsets, field positions, reset values and sizes of the video receive path
// assumes inclusion by the receive path module
`ifndef SDIVR_PARAMS_SVH
`define SDIVR_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SDIVR_OFS_PICCTL 4'h0
`define SDIVR_OFS_FMTCTL 4'h4
`define SDIVR_OFS_ANCCTL 4'h8
`define SDIVR_OFS_STATUS 4'hc

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SDIVR_B_LSB_EN 0
`define SDIVR_B_VLSB_EN 1
`define SDIVR_B_FORCE_EN 5
`define SDIVR_B_STANDARD_DEF_RESTRICT 6
`define SDIVR_B_HIGH_DEF_RESTRICT 7
`define SDIVR_B_CODE_HD 4

// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define SDIVR_RST_PICCTL 2'h0
`define SDIVR_RST_FMTCTL 8'h00
`define SDIVR_RST_DEPTH 3'h0
`define SDIVR_SD_BITS 5'h0a
`define SDIVR_HD_BITS 5'h14
`define SDIVR_MAX_DEPTH 3'h4
`define SDIVR_W_ALL1 10'h3ff
`define SDIVR_W_ALL0 10'h000
`define SDIVR_CLIP_LO 10'h003
`define SDIVR_CLIP_HI 10'h3fc

`endif

// file: src/sdivr_pkg.sv
// types of the video receive path
// assumes the params header is compiled alongside
`default_nettype none
package sdivr_pkg;
	typedef enum logic [1:0] {
		SDIVR_FMT_HUNT = 2'b00,
		SDIVR_FMT_SD = 2'b01,
		SDIVR_FMT_HD = 2'b10
	} sdivr_fmt_type;

	typedef logic [31:0] sdivr_word_type;
	typedef logic [19:0] sdivr_vid_type;
endpackage
`default_nettype wire

// file: src/sdivr_rx.sv
// receive path: descramble, word build, trs align, clip, format, delay
// assumes one serial bit per mclk_in cycle and an axi4-lite master
`timescale 1ns/100ps
`default_nettype none
`include "sdivr_params.svh"

module sdivr_rx (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic serial_input_pair_in,
	input wire logic pll_lock_in,
	output logic [19:0] video_out_bus_out,
	output logic recovered_word_clock_out,
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire sdivr_pkg::sdivr_word_type s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output sdivr_pkg::sdivr_word_type s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	import sdivr_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] ser_sync;
		logic [1:0] lock_sync;
		logic prev_line;
		logic [8:0] nrz_hist;
		logic [59:0] shreg;
		logic [4:0] bit_cnt;
		sdivr_fmt_type fmt;
		logic xyz_next;
		logic vblank;
		logic eav;
		logic sav;
		logic new_sync_position_flag;
		logic [3:0][19:0] fifo;
		sdivr_vid_type vout;
		logic wclk;
		logic [1:0] picctl;
		logic [7:0] fmtctl;
		logic [2:0] depth;
		logic aw_have;
		logic [3:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		sdivr_word_type rdata;
	} sdivr_state_type;

	sdivr_state_type st_q;
	sdivr_state_type st_d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// timing character lsb clipping
	function automatic logic [9:0] clip10(input logic [9:0] w);
		if (w <= `SDIVR_CLIP_LO) begin
			clip10 = `SDIVR_W_ALL0;
		end else if (w >= `SDIVR_CLIP_HI) begin
			clip10 = `SDIVR_W_ALL1;
		end else begin
			clip10 = w;
		end
	endfunction

	// dither removal: drop the noisy lsb
	function automatic logic [9:0] undither(input logic [9:0] w, input logic on);
		undither = on ? {w[9:1], 1'b0} : w;
	endfunction

	// register address decode
	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == `SDIVR_OFS_PICCTL) || (a == `SDIVR_OFS_FMTCTL) ||
			(a == `SDIVR_OFS_ANCCTL) || (a == `SDIVR_OFS_STATUS);
	endfunction

	logic nrz_bit;
	logic ds_bit;
	logic [59:0] sh_new;
	logic hd;
	logic [4:0] wlen;
	logic sd_hit;
	logic hd_hit;
	logic trs_hit;
	logic emit;
	logic dd_on;
	sdivr_vid_type raw_w;
	sdivr_vid_type new_w;
	logic [9:0] xyz;
	logic [4:0] cnt_n;
	logic lock;
	logic aw_go;
	logic w_go;

	// ---------------------------------------------------------------
	// serial front end
	// ---------------------------------------------------------------
	// nrzi decode and self-sync descramble on the synced line
	assign nrz_bit = st_q.ser_sync[1] ^ st_q.prev_line;
	assign ds_bit = nrz_bit ^ st_q.nrz_hist[3] ^ st_q.nrz_hist[8];
	assign sh_new = {ds_bit, st_q.shreg[59:1]};
	assign lock = st_q.lock_sync[1];
	assign hd = (st_q.fmt == SDIVR_FMT_HD);
	assign wlen = hd ? `SDIVR_HD_BITS : `SDIVR_SD_BITS;

	// trs preamble search at every bit position
	assign sd_hit = (sh_new[39:30] == `SDIVR_W_ALL1) && (sh_new[59:40] == 20'h00000) &&
		(sh_new[29:20] != `SDIVR_W_ALL1) && !st_q.fmtctl[`SDIVR_B_HIGH_DEF_RESTRICT];
	assign hd_hit = (sh_new[19:0] == {`SDIVR_W_ALL1, `SDIVR_W_ALL1}) &&
		(sh_new[59:20] == 40'h0000000000) && !st_q.fmtctl[`SDIVR_B_STANDARD_DEF_RESTRICT];
	assign trs_hit = hd ? hd_hit : (st_q.fmt == SDIVR_FMT_SD) && sd_hit;
	assign emit = trs_hit || (st_q.bit_cnt == wlen - 5'h01);
	assign cnt_n = emit ? 5'h00 : st_q.bit_cnt + 5'h01;

	// ---------------------------------------------------------------
	// word processing
	// ---------------------------------------------------------------
	// low half is the earlier word: chroma in hd
	assign raw_w = hd ? sh_new[59:40] : {sh_new[59:50], sh_new[59:50]};
	assign dd_on = st_q.picctl[`SDIVR_B_LSB_EN] &&
		(!st_q.vblank || st_q.picctl[`SDIVR_B_VLSB_EN]);
	assign new_w = {clip10(undither(raw_w[19:10], dd_on)),
		clip10(undither(raw_w[9:0], dd_on))};
	assign xyz = raw_w[19:10];

	// ---------------------------------------------------------------
	// axi handshakes
	// ---------------------------------------------------------------
	// no item is offered as taken while the enable freezes the state
	assign s_axi_awready_out = ce_in && !st_q.aw_have && !st_q.bvalid;
	assign s_axi_wready_out = ce_in && !st_q.w_have && !st_q.bvalid;
	assign s_axi_arready_out = ce_in && !st_q.rvalid;
	assign aw_go = s_axi_awvalid_in && s_axi_awready_out;
	assign w_go = s_axi_wvalid_in && s_axi_wready_out;

	// next state of the whole block
	always_comb begin
		st_d = st_q;
		st_d.ser_sync = {st_q.ser_sync[0], serial_input_pair_in};
		st_d.lock_sync = {st_q.lock_sync[0], pll_lock_in};
		st_d.prev_line = st_q.ser_sync[1];
		st_d.nrz_hist = {st_q.nrz_hist[7:0], nrz_bit};
		st_d.shreg = sh_new;
		st_d.bit_cnt = cnt_n;
		st_d.wclk = (cnt_n >= (wlen >> 1));
		// format tracking, only with pll lock
		if (!lock) begin
			st_d.fmt = SDIVR_FMT_HUNT;
		end else if (st_q.fmtctl[`SDIVR_B_FORCE_EN]) begin
			st_d.fmt = st_q.fmtctl[`SDIVR_B_CODE_HD] ? SDIVR_FMT_HD : SDIVR_FMT_SD;
		end else if (hd && st_q.fmtctl[`SDIVR_B_STANDARD_DEF_RESTRICT]) begin
			st_d.fmt = SDIVR_FMT_HUNT;
		end else if (st_q.fmt == SDIVR_FMT_SD && st_q.fmtctl[`SDIVR_B_HIGH_DEF_RESTRICT]) begin
			st_d.fmt = SDIVR_FMT_HUNT;
		end else if (st_q.fmt == SDIVR_FMT_HUNT) begin
			if (hd_hit) begin
				st_d.fmt = SDIVR_FMT_HD;
			end else if (sd_hit) begin
				st_d.fmt = SDIVR_FMT_SD;
			end
		end
		// any format change restarts the word count, so the next word
		// ends only after a full high phase of the word clock
		if (st_d.fmt != st_q.fmt) begin
			st_d.bit_cnt = 5'h00;
		end
		// word boundary: flags, delay line, output
		if (emit) begin
			st_d.new_sync_position_flag = trs_hit && (st_q.bit_cnt != wlen - 5'h01);
			st_d.xyz_next = trs_hit;
			st_d.eav = st_q.xyz_next && xyz[6];
			st_d.sav = st_q.xyz_next && !xyz[6];
			if (st_q.xyz_next) begin
				st_d.vblank = xyz[7];
			end
			if (st_q.depth == 3'h0) begin
				st_d.vout = new_w;
			end else if (st_q.depth >= `SDIVR_MAX_DEPTH) begin
				st_d.vout = st_q.fifo[3];
			end else begin
				st_d.vout = st_q.fifo[st_q.depth[1:0] - 2'h1];
			end
			for (int i = 3; i > 0; i--) begin
				st_d.fifo[i] = st_q.fifo[i - 1];
			end
			st_d.fifo[0] = new_w;
		end
		// write channel: address and data in either order
		if (aw_go) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = s_axi_awaddr_in;
		end
		if (w_go) begin
			st_d.w_have = 1'b1;
			st_d.w_data = s_axi_wdata_in[7:0];
			st_d.w_lane0 = s_axi_wstrb_in[0];
		end
		if (st_q.aw_have && st_q.w_have) begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = mapped(st_q.aw_addr) ? 2'b00 : 2'b10;
			if (st_q.w_lane0) begin
				case (st_q.aw_addr)
					`SDIVR_OFS_PICCTL: st_d.picctl = st_q.w_data[1:0];
					`SDIVR_OFS_FMTCTL: st_d.fmtctl = st_q.w_data;
					`SDIVR_OFS_ANCCTL: st_d.depth = st_q.w_data[2:0];
					default: st_d.depth = st_q.depth;
				endcase
			end
		end
		if (st_q.bvalid && s_axi_bready_in) begin
			st_d.bvalid = 1'b0;
		end
		// read channel
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = mapped(s_axi_araddr_in) ? 2'b00 : 2'b10;
			case (s_axi_araddr_in)
				`SDIVR_OFS_PICCTL: st_d.rdata = {30'h00000000, st_q.picctl};
				`SDIVR_OFS_FMTCTL: st_d.rdata = {24'h000000, st_q.fmtctl};
				`SDIVR_OFS_ANCCTL: st_d.rdata = {29'h00000000, st_q.depth};
				`SDIVR_OFS_STATUS: st_d.rdata = {25'h0000000, st_q.vblank, st_q.new_sync_position_flag,
					st_q.sav, st_q.eav, st_q.fmt, lock};
				default: st_d.rdata = 32'h00000000;
			endcase
		end else if (st_q.rvalid && s_axi_rready_in) begin
			st_d.rvalid = 1'b0;
		end
	end

	// state register, frozen while ce_in is low
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.fmt <= SDIVR_FMT_HUNT;
			st_q.picctl <= `SDIVR_RST_PICCTL;
			st_q.fmtctl <= `SDIVR_RST_FMTCTL;
			st_q.depth <= `SDIVR_RST_DEPTH;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign video_out_bus_out = st_q.vout;
	assign recovered_word_clock_out = st_q.wclk;
	assign s_axi_bvalid_out = st_q.bvalid;
	assign s_axi_bresp_out = st_q.bresp;
	assign s_axi_rvalid_out = st_q.rvalid;
	assign s_axi_rresp_out = st_q.rresp;
	assign s_axi_rdata_out = st_q.rdata;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_clip_low;
		@(posedge mclk_in) disable iff (rst_in)
		!(st_q.vout[9:0] inside {10'h001, 10'h002, 10'h003});
	endproperty
	a_clip_low: assert property (p_clip_low) else $error("low trs value not clipped");

	property p_clip_high;
		@(posedge mclk_in) disable iff (rst_in)
		!(st_q.vout[19:10] inside {10'h3fc, 10'h3fd, 10'h3fe});
	endproperty
	a_clip_high: assert property (p_clip_high) else $error("high trs value not clipped");

	property p_change_on_fall;
		@(posedge mclk_in) disable iff (rst_in)
		$changed(video_out_bus_out) |-> !recovered_word_clock_out && $past(st_q.wclk);
	endproperty
	a_change_on_fall: assert property (p_change_on_fall) else $error("word changed off fall");

	property p_cfg_after_reset;
		@(posedge mclk_in)
		$fell(rst_in) |-> st_q.picctl == 2'h0;
	endproperty
	a_cfg_after_reset: assert property (p_cfg_after_reset) else $error("restore enabled at reset");

	property p_sd_dup;
		@(posedge mclk_in) disable iff (rst_in)
		!hd |-> new_w[19:10] == new_w[9:0];
	endproperty
	a_sd_dup: assert property (p_sd_dup) else $error("sd word not duplicated");

	property p_zero_delay;
		@(posedge mclk_in) disable iff (rst_in)
		ce_in && emit && st_q.depth == 3'h0 |=> video_out_bus_out == $past(new_w);
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay word wrong");

	property p_standard_def_restrict;
		@(posedge mclk_in) disable iff (rst_in)
		ce_in && hd && st_q.fmtctl[`SDIVR_B_STANDARD_DEF_RESTRICT] && !st_q.fmtctl[`SDIVR_B_FORCE_EN]
		|=> st_q.fmt != SDIVR_FMT_HD;
	endproperty
	a_standard_def_restrict: assert property (p_standard_def_restrict) else $error("hd kept under sd restrict");

	property p_no_lock;
		@(posedge mclk_in) disable iff (rst_in)
		ce_in && !lock |=> st_q.fmt == SDIVR_FMT_HUNT;
	endproperty
	a_no_lock: assert property (p_no_lock) else $error("format held without lock");

	property p_realign;
		@(posedge mclk_in) disable iff (rst_in)
		ce_in && trs_hit |=> st_q.bit_cnt == 5'h00 && st_q.xyz_next;
	endproperty
	a_realign: assert property (p_realign) else $error("no realign on trs");

	property p_forced;
		@(posedge mclk_in) disable iff (rst_in)
		ce_in && lock && st_q.fmtctl[`SDIVR_B_FORCE_EN] |=>
			st_q.fmt == ($past(st_q.fmtctl[4]) ? SDIVR_FMT_HD : SDIVR_FMT_SD);
	endproperty
	a_forced: assert property (p_forced) else $error("forced format ignored");

	c_trs: cover property (@(posedge mclk_in) disable iff (rst_in) trs_hit);
	c_hd: cover property (@(posedge mclk_in) disable iff (rst_in) st_q.fmt == SDIVR_FMT_HD);
	c_nsp: cover property (@(posedge mclk_in) disable iff (rst_in) st_q.new_sync_position_flag);
endmodule // sdivr_rx
`default_nettype wire

// file: tb/sdivr_src.sv
// serial video source model feeding the receive path
// assumes one serial bit per clock while ce_in is high
`timescale 1ns/100ps
`default_nettype none

module sdivr_src (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	output logic ser_out
);
	logic [9:0] q[$];
	logic [9:0] w_q;
	logic [3:0] n_q;
	logic [8:0] sr_q;
	logic s;

	// scrambled bit of the current serial position
	assign s = w_q[n_q] ^ sr_q[3] ^ sr_q[8];

	// ----
	// word queue
	// ----
	// bench loads words here; idle black level when empty
	function automatic void push(input logic [9:0] v);
		q.push_back(v);
	endfunction

	// scramble, nrzi encode, lsb first
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			w_q <= 10'h040;
			n_q <= 4'h0;
			sr_q <= 9'h000;
			ser_out <= 1'b0;
		end else if (ce_in) begin
			sr_q <= {sr_q[7:0], s};
			ser_out <= ser_out ^ s;
			n_q <= (n_q == 4'h9) ? 4'h0 : n_q + 4'h1;
			if (n_q == 4'h9) begin
				w_q <= (q.size() > 0) ? q.pop_front() : 10'h040;
			end
		end
	end
endmodule // sdivr_src

`default_nettype wire

// file: tb/sdivr_rx_tb.sv
// self-checking bench of the video receive path
// assumes the source model and an axi4-lite master driven here
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module sdivr_rx_tb;
	import sdivr_pkg::*;
	logic mclk, rst, ce, lock, ser, wclk, awv, wv, bv, br, arv, rv, rr, awr, wr, arr;
	logic pc, rnd_ce, started;
	logic [3:0] awa, ara;
	sdivr_word_type wd, rd;
	logic [1:0] bresp, rresp, be;
	logic [19:0] vout, pv, ev;
	logic [65:0] re;
	logic [19:0] vq[$];
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	int n_errors, samples_checked, seed;

	sdivr_rx DUT (.mclk_in(mclk), .rst_in(rst), .ce_in(ce), .serial_input_pair_in(ser),
		.pll_lock_in(lock), .video_out_bus_out(vout), .recovered_word_clock_out(wclk),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
	sdivr_src src (.clk_in(mclk), .rst_in(rst), .ce_in(ce), .ser_out(ser));

	// ----
	// clock, enable, watchdog
	// ----
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// enable drops about one cycle in eight during random phases
	always @(posedge mclk) ce <= rnd_ce ? (($random(seed) & 7) != 0) : 1'b1;

	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		summarize();
	end

	// ----
	// bus and stream tasks
	// ----
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge mclk);
		bq.push_back(r);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!(ad && dd)) begin
			@(negedge mclk);
			ad = ad | (awv & awr);
			dd = dd | (wv & wr);
			@(posedge mclk);
			if (ad) awv <= 1'b0;
			if (dd) wv <= 1'b0;
		end
		do begin
			@(negedge mclk);
			ad = bv;
			@(posedge mclk);
		end while (!ad);
		br <= 1'b0;
	endtask

	// read with a mask on the compared bits
	task automatic axr(input logic [3:0] a, input logic [31:0] m, d, input logic [1:0] r);
		logic t;
		@(posedge mclk);
		rq.push_back({r, m, d});
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(negedge mclk);
			t = arr;
			@(posedge mclk);
		end while (!t);
		arv <= 1'b0;
		do begin
			@(negedge mclk);
			t = rv;
			@(posedge mclk);
		end while (!t);
		rr <= 1'b0;
	endtask

	// preamble to align, marker, trs, clip cases, random words
	task automatic frame(input logic [9:0] xyz, input logic dd, input logic chk);
		logic [9:0] w, e;
		logic [9:0] fix [17];
		fix = '{10'h3ff, 10'h000, 10'h000, 10'h200, 10'h040, 10'h040, 10'h3a4, 10'h3ff,
			10'h000, 10'h000, xyz, 10'h001, 10'h002, 10'h3fd, 10'h3fe, 10'h155, 10'h2aa};
		for (int i = 0; i < 33; i++) begin
			w = (i < 17) ? fix[i] : 10'h004 + 10'({$random(seed)} % 508);
			src.push(w);
			e = dd ? (w & 10'h3fe) : w;
			if (e <= 10'h003) e = 10'h000;
			if (e >= 10'h3fc) e = 10'h3ff;
			if (chk && i > 5) vq.push_back({e, e});
		end
		drain(chk);
	endtask

	// wait until source and expected words have drained
	task automatic drain(input logic chk);
		int n;
		n = 0;
		while ((src.q.size() > 0 || vq.size() > 0) && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		repeat (120) @(posedge mclk);
		if (chk) `CHK(vq.size(), 0)
	endtask

	// hd frame: six-word trs preamble, xyz pair, random pairs; earlier word is chroma
	task automatic hdframe(input logic [9:0] xyz);
		logic [9:0] w [40];
		logic [9:0] e [40];
		for (int i = 0; i < 40; i++) begin
			w[i] = (i < 2) ? 10'h3ff : (i < 6) ? 10'h000 : (i < 8) ? xyz :
				10'h004 + 10'({$random(seed)} % 508);
			src.push(w[i]);
			e[i] = w[i] & 10'h3fe;
			if (e[i] <= 10'h003) e[i] = 10'h000;
			if (e[i] >= 10'h3fc) e[i] = 10'h3ff;
			if (i > 5 && i[0]) vq.push_back({e[i], e[i - 1]});
		end
		drain(1'b1);
	endtask

	// ----
	// result watchers
	// ----
	// word captured at the word clock rise
	always @(posedge wclk) begin
		if (!started && vq.size() > 0 && vout === vq[0]) started = 1'b1;
		if (started) begin
			ev = vq.pop_front();
			`CHK(vout, ev)
			if (vq.size() == 0) started = 1'b0;
		end
	end

	// output word only moves where the word clock falls
	always @(negedge mclk) begin
		if (!rst && !(pc && !wclk)) `CHK(vout, pv)
		pv = vout;
		pc = wclk;
		if (bv && br) begin
			be = bq.pop_front();
			`CHK(bresp, be)
		end
		if (rv && rr) begin
			re = rq.pop_front();
			`CHK({rresp, rd & re[63:32]}, {re[65:64], re[31:0]})
		end
	end

	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		seed = 27;
		n_errors = 0;
		samples_checked = 0;
		{rst, ce, lock, awv, wv, br, arv, rr, rnd_ce, started, pc} = 11'b11000000000;
		{awa, ara, wd, pv} = '0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		axr(4'h0, 32'hffffffff, 32'h0, 2'b00);
		axr(4'h4, 32'hffffffff, 32'h0, 2'b00);
		axr(4'h6, 32'hffffffff, 32'h0, 2'b10);
		axw(4'h6, 32'h1, 2'b10);
		axw(4'h8, 32'h4, 2'b00);
		axr(4'h8, 32'h7, 32'h4, 2'b00);
		lock <= 1'b1;
		rnd_ce = 1'b1;
		frame(10'h200, 1'b0, 1'b1);
		rnd_ce = 1'b0;
		axr(4'hc, 32'h7, 32'h3, 2'b00);
		axw(4'h0, 32'h1, 2'b00);
		frame(10'h200, 1'b1, 1'b1);
		frame(10'h2ac, 1'b0, 1'b1);
		axw(4'h0, 32'h3, 2'b00);
		axr(4'h0, 32'h3, 32'h3, 2'b00);
		frame(10'h2ac, 1'b1, 1'b1);
		axw(4'h4, 32'h80, 2'b00);
		frame(10'h200, 1'b1, 1'b0);
		axr(4'hc, 32'h6, 32'h0, 2'b00);
		axw(4'h4, 32'h40, 2'b00);
		frame(10'h200, 1'b1, 1'b1);
		axr(4'hc, 32'h6, 32'h2, 2'b00);
		axw(4'h4, 32'h20, 2'b00);
		frame(10'h200, 1'b1, 1'b1);
		axr(4'hc, 32'h6, 32'h2, 2'b00);
		axw(4'h4, 32'h80, 2'b00);
		hdframe(10'h274);
		axr(4'hc, 32'h6, 32'h4, 2'b00);
		axw(4'h4, 32'h40, 2'b00);
		axr(4'hc, 32'h6, 32'h0, 2'b00);
		lock <= 1'b0;
		repeat (4) @(posedge mclk);
		axr(4'hc, 32'h7, 32'h0, 2'b00);
		summarize();
	end
endmodule // sdivr_rx_tb

`default_nettype wire
